// file: hw/att_trim_queue.sv
// Axis trim registers, trim datapath, sample queue and its control over AHB-Lite.
`timescale 1ns/10ps
module att_trim_queue
  import att_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire att_trim_t otpTrim,
  input wire logic otpReload,
  input wire logic sampleValid,
  input wire att_axis_t sampleIn,
  output logic trimValid,
  output att_axis_t trimOut,
  input wire logic popReq,
  output logic popValid,
  output att_axis_t popData,
  input wire logic motionIrq,
  output logic irq,
  output logic irqPinPrimary,
  output logic irqPinSecondary
);

  att_trim_t trim_r;
  logic loadPend_r;
  logic [7:0] ctrl_r;
  logic [4:0] level_r;
  logic [2:0] status_r;
  logic [2:0] mask_r;
  logic qRst_r;
  logic readyOut_r;
  logic rdPend_r;
  logic wrPend_r;
  logic [7:0] idx_r;
  logic [31:0] hrdata_r;
  logic trimValid_r;
  att_axis_t trimOut_r;
  logic popValid_r;
  att_axis_t popData_r;
  att_axis_t qMem [0:31];
  logic [Q_AW-1:0] wrPtr_r;
  logic [Q_AW-1:0] rdPtr_r;
  logic [Q_AW:0] count_r;
  logic [Q_AW:0] count_nxt;
  logic addrTake;
  logic wrData;
  logic [7:0] wByte;
  logic qEn;
  logic qMode;
  logic merge;
  logic atLevel;
  logic push;
  logic pop;
  logic [2:0] event_s;
  logic [2:0] clear_s;
  logic queueIrq;
  logic [15:0] axIn [0:2];
  logic [15:0] axOff [0:2];
  logic [8:0] axGain [0:2];
  logic [15:0] axOut [0:2];

  // Bus front end: writes complete with no wait state, reads take one.
  assign addrTake = ce && hsel && hready && htrans[1];
  assign wrData = ce && wrPend_r;
  assign wByte = hwdata[7:0];
  assign hreadyout = readyOut_r && ce;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      readyOut_r <= 1'b1;
      rdPend_r <= 1'b0;
      wrPend_r <= 1'b0;
      idx_r <= 8'h00;
    end else if (ce) begin
      rdPend_r <= addrTake && !hwrite;
      wrPend_r <= addrTake && hwrite;
      readyOut_r <= !(addrTake && !hwrite);
      if (addrTake) begin
        idx_r <= haddr[9:2];
      end
    end
  end

  function automatic logic [7:0] readMux(input logic [7:0] idx);
    case (idx)
      IDX_X_OFF_HIGH: readMux = {trim_r.x_gain_low_byte[8], trim_r.xOffHi};
      IDX_Y_OFF_LOW: readMux = trim_r.y_offset_trim[7:0];
      IDX_Y_OFF_HIGH: readMux = {trim_r.y_gain_low_byte[8], trim_r.y_offset_trim[14:8]};
      IDX_Z_OFF_LOW: readMux = trim_r.z_offset_trim[7:0];
      IDX_Z_OFF_HIGH: readMux = {trim_r.z_gain_low_byte[8], trim_r.z_offset_trim[14:8]};
      IDX_X_GAIN_LOW: readMux = trim_r.x_gain_low_byte[7:0];
      IDX_Y_GAIN_LOW: readMux = trim_r.y_gain_low_byte[7:0];
      IDX_Z_GAIN_LOW: readMux = trim_r.z_gain_low_byte[7:0];
      IDX_QCTRL: readMux = ctrl_r;
      IDX_QLEVEL: readMux = {3'h0, level_r};
      IDX_QSTAT: readMux = {5'h00, status_r};
      IDX_QMASK: readMux = {5'h00, mask_r};
      IDX_QCOUNT: readMux = {2'h0, count_r};
      default: readMux = 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk) begin
    if (!nrst) begin
      hrdata_r <= 32'h0000_0000;
    end else if (ce && rdPend_r) begin
      hrdata_r <= {24'h00_0000, readMux(idx_r)};
    end
  end

  // Trim values are captured from one-time memory on the first cycle after reset.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      loadPend_r <= 1'b1;
    end else if (ce) begin
      loadPend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      trim_r <= '0;
    end else if (ce) begin
      if (loadPend_r || otpReload) begin
        trim_r <= otpTrim;
      end else if (wrData) begin
        case (idx_r)
          IDX_X_OFF_HIGH: {trim_r.x_gain_low_byte[8], trim_r.xOffHi} <= wByte;
          IDX_Y_OFF_LOW: trim_r.y_offset_trim[7:0] <= wByte;
          IDX_Y_OFF_HIGH: {trim_r.y_gain_low_byte[8], trim_r.y_offset_trim[14:8]} <= wByte;
          IDX_Z_OFF_LOW: trim_r.z_offset_trim[7:0] <= wByte;
          IDX_Z_OFF_HIGH: {trim_r.z_gain_low_byte[8], trim_r.z_offset_trim[14:8]} <= wByte;
          IDX_X_GAIN_LOW: trim_r.x_gain_low_byte[7:0] <= wByte;
          IDX_Y_GAIN_LOW: trim_r.y_gain_low_byte[7:0] <= wByte;
          IDX_Z_GAIN_LOW: trim_r.z_gain_low_byte[7:0] <= wByte;
          default: trim_r <= trim_r;
        endcase
      end
    end
  end

  // Control bits 4 and 7 are never stored, so they read back as zero.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_r <= QCTRL_RESET;
      level_r <= LEVEL_RESET;
      mask_r <= 3'h0;
      qRst_r <= 1'b0;
    end else if (ce) begin
      qRst_r <= wrData && (idx_r == IDX_QCTRL) && wByte[QC_RESET];
      if (wrData && idx_r == IDX_QCTRL) begin
        ctrl_r <= wByte & QCTRL_WMASK;
      end
      if (wrData && idx_r == IDX_QLEVEL) begin
        level_r <= wByte[4:0];
      end
      if (wrData && idx_r == IDX_QMASK) begin
        mask_r <= wByte[2:0];
      end
    end
  end

  // Trim datapath: offset first, then gain with 256 as unity.
  assign axIn[0] = sampleIn.x;
  assign axIn[1] = sampleIn.y;
  assign axIn[2] = sampleIn.z;
  assign axOff[0] = {trim_r.xOffHi[6], trim_r.xOffHi, 8'h00};
  assign axOff[1] = {trim_r.y_offset_trim[14], trim_r.y_offset_trim};
  assign axOff[2] = {trim_r.z_offset_trim[14], trim_r.z_offset_trim};
  assign axGain[0] = trim_r.x_gain_low_byte;
  assign axGain[1] = trim_r.y_gain_low_byte;
  assign axGain[2] = trim_r.z_gain_low_byte;

  for (genvar a = 0; a < 3; a++) begin : g_axis
    logic signed [16:0] sum;
    logic signed [26:0] prod;
    assign sum = $signed({axIn[a][15], axIn[a]}) + $signed({axOff[a][15], axOff[a]});
    assign prod = sum * $signed({1'b0, axGain[a]});
    assign axOut[a] = prod[GAIN_SHIFT+15:GAIN_SHIFT];
  end

  // Trims are sampled in the accept cycle, so a write only affects later samples.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trimValid_r <= 1'b0;
      trimOut_r <= '0;
    end else if (ce) begin
      trimValid_r <= sampleValid;
      if (sampleValid) begin
        trimOut_r <= '{x: axOut[0], y: axOut[1], z: axOut[2]};
      end
    end
  end

  assign trimValid = trimValid_r;
  assign trimOut = trimOut_r;

  // Sample queue.
  assign qEn = ctrl_r[QC_ENABLE];
  assign qMode = ctrl_r[QC_MODE];
  assign merge = ctrl_r[QC_MERGE];
  assign atLevel = count_r >= {1'b0, level_r};
  assign push = ce && qEn && !qRst_r && trimValid_r && (count_r != Q_DEPTH)
    && !(qMode && atLevel);
  assign pop = ce && qEn && !qRst_r && popReq && (count_r != '0);

  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 6'h01;
    end else if (pop && !push) begin
      count_nxt = count_r - 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      qMem[wrPtr_r] <= trimOut_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (ce) begin
      if (qRst_r) begin
        wrPtr_r <= '0;
        rdPtr_r <= '0;
        count_r <= '0;
      end else begin
        wrPtr_r <= wrPtr_r + Q_AW'(push);
        rdPtr_r <= rdPtr_r + Q_AW'(pop);
        count_r <= count_nxt;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      popValid_r <= 1'b0;
      popData_r <= '0;
    end else if (ce) begin
      popValid_r <= pop;
      if (pop) begin
        popData_r <= qMem[rdPtr_r];
      end
    end
  end

  assign popValid = popValid_r;
  assign popData = popData_r;

  // Events are only seen while their enable is set; a set beats a same-cycle clear.
  assign event_s[ST_EMPTY] = ctrl_r[QC_EMPTY_EN] && pop && !push && (count_r == 6'h01);
  assign event_s[ST_FULL] = ctrl_r[QC_FULL_EN] && push && !pop
    && (count_r == Q_DEPTH - 6'h01);
  assign event_s[ST_LEVEL] = ctrl_r[QC_LEVEL_EN] && !atLevel
    && (count_nxt >= {1'b0, level_r}) && !qRst_r;
  assign clear_s = (wrData && idx_r == IDX_QSTAT) ? wByte[2:0] : 3'h0;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      status_r <= 3'h0;
    end else if (ce) begin
      status_r <= (status_r & ~clear_s) | event_s;
    end
  end

  assign queueIrq = |(status_r & mask_r);
  assign irq = queueIrq;
  assign irqPinPrimary = motionIrq || (merge && queueIrq);
  assign irqPinSecondary = !merge && queueIrq;

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence ctrlWrite(int b);
    wrData && idx_r == IDX_QCTRL && wByte[b];
  endsequence

  AST_Y_OFFSET: assert property (
    ce && sampleValid && trim_r.y_gain_low_byte == GAIN_UNITY
    |=> trimOut_r.y == 16'($past(sampleIn.y) + $past(axOff[1])))
    else $error("Y output does not carry the Y offset trim");

  AST_Z_OFFSET: assert property (
    ce && sampleValid && trim_r.z_gain_low_byte == GAIN_UNITY
    |=> trimOut_r.z == 16'($past(sampleIn.z) + $past(axOff[2])))
    else $error("Z output does not carry the Z offset trim");

  AST_OTP_LOAD: assert property (
    nrst && ce && loadPend_r |=> trim_r == $past(otpTrim) && !loadPend_r)
    else $error("Trim not loaded from one-time memory after reset");

  AST_Y_GAIN_MSB: assert property (
    ce && rdPend_r && idx_r == IDX_Y_OFF_HIGH && !loadPend_r && !otpReload
    |=> hrdata_r[7] == $past(trim_r.y_gain_low_byte[8]) && readyOut_r)
    else $error("Y offset high byte bit 7 is not the Y gain MSB");

  AST_X_GAIN_MSB: assert property (
    wrData && idx_r == IDX_X_OFF_HIGH && !loadPend_r && !otpReload
    |=> trim_r.x_gain_low_byte[8] == $past(wByte[7]) && trim_r.xOffHi == $past(wByte[6:0]))
    else $error("X offset high byte write misplaced the gain MSB");

  AST_MERGE: assert property (
    merge |-> !irqPinSecondary && irqPinPrimary == (motionIrq || queueIrq))
    else $error("Merged interrupts not all on the primary pin");

  AST_SPLIT: assert property (
    !merge |-> irqPinSecondary == queueIrq && irqPinPrimary == motionIrq)
    else $error("Split interrupt routing wrong");

  AST_QRESET: assert property (
    ctrlWrite(QC_RESET) ##1 ce |=> count_r == '0 && wrPtr_r == '0 && rdPtr_r == '0)
    else $error("Queue reset did not clear pointers");

  AST_QUEUE_OFF: assert property (
    !qEn |-> !push && !pop)
    else $error("Queue moved while disabled");

  AST_NORMAL_FILL: assert property (
    ce && qEn && !qMode && !qRst_r && trimValid_r && count_r != Q_DEPTH |-> push)
    else $error("Normal mode dropped a sample with space left");

  AST_WATERMARK: assert property (
    qMode && atLevel |-> !push ##1 (count_r <= $past(count_r)))
    else $error("Watermark mode accepted a sample at the level");

  AST_FLAG_GATED: assert property (
    ce && $rose(status_r[ST_EMPTY]) |-> $past(ctrl_r[QC_EMPTY_EN]))
    else $error("Empty flag raised while its enable was clear");

endmodule

// file: hw/att_pkg.sv
// Constants, register map and carrier types of the axis trim and queue control block.
package att_pkg;

  localparam logic [7:0] IDX_X_OFF_HIGH = 8'h22;
  localparam logic [7:0] IDX_Y_OFF_LOW = 8'h23;
  localparam logic [7:0] IDX_Y_OFF_HIGH = 8'h24;
  localparam logic [7:0] IDX_Z_OFF_LOW = 8'h25;
  localparam logic [7:0] IDX_Z_OFF_HIGH = 8'h26;
  localparam logic [7:0] IDX_X_GAIN_LOW = 8'h27;
  localparam logic [7:0] IDX_Y_GAIN_LOW = 8'h28;
  localparam logic [7:0] IDX_Z_GAIN_LOW = 8'h29;
  localparam logic [7:0] IDX_QCTRL = 8'h2D;
  localparam logic [7:0] IDX_QLEVEL = 8'h2E;
  localparam logic [7:0] IDX_QSTAT = 8'h31;
  localparam logic [7:0] IDX_QMASK = 8'h32;
  localparam logic [7:0] IDX_QCOUNT = 8'h33;

  localparam int QC_EMPTY_EN = 0;
  localparam int QC_FULL_EN = 1;
  localparam int QC_LEVEL_EN = 2;
  localparam int QC_MERGE = 3;
  localparam int QC_RESET = 4;
  localparam int QC_ENABLE = 5;
  localparam int QC_MODE = 6;
  localparam logic [7:0] QCTRL_RESET = 8'h00;
  localparam logic [7:0] QCTRL_WMASK = 8'h6F;

  localparam int ST_EMPTY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_LEVEL = 2;

  localparam int Q_AW = 5;
  localparam logic [Q_AW:0] Q_DEPTH = 6'h20;
  localparam logic [4:0] LEVEL_RESET = 5'h10;
  localparam int GAIN_SHIFT = 8;
  localparam logic [8:0] GAIN_UNITY = 9'h100;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } att_axis_t;

  typedef struct packed {
    logic [6:0] xOffHi;
    logic [14:0] y_offset_trim;
    logic [14:0] z_offset_trim;
    logic [8:0] x_gain_low_byte;
    logic [8:0] y_gain_low_byte;
    logic [8:0] z_gain_low_byte;
  } att_trim_t;

endpackage

// file: sim/att_host_model.sv
// Host processor model acting as the AHB-Lite master of the register bus.
`timescale 1ns/10ps
module att_host_model (
  input wire logic clk,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Must be entered just after a rising edge; one byte travels in bits 7:0 of the word.
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata[7:0];
  endtask
endmodule

// file: sim/att_trim_queue_tb.sv
// Self-checking bench for the trim registers, trim datapath and sample queue.
`timescale 1ns/10ps
module att_trim_queue_tb;
  import att_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, otpReload, sampleValid, trimValid;
  logic popReq, popValid, motionIrq, irq, irqPinPrimary, irqPinSecondary;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  att_trim_t otpTrim;
  att_axis_t sampleIn, trimOut, popData;
  att_axis_t mq[$];
  logic [15:0] seed = 16'h2FBD;
  logic [63:0] img;
  logic [7:0] rb;
  logic qen = 1'b0;
  logic qmode = 1'b0;
  int lvl = 16;
  int errors = 0;
  int compares = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  att_trim_queue u_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .otpTrim(otpTrim),
    .otpReload(otpReload), .sampleValid(sampleValid), .sampleIn(sampleIn),
    .trimValid(trimValid), .trimOut(trimOut), .popReq(popReq), .popValid(popValid),
    .popData(popData), .motionIrq(motionIrq), .irq(irq), .irqPinPrimary(irqPinPrimary),
    .irqPinSecondary(irqPinSecondary));

  att_host_model u_host (.clk(clk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [15:0] tr(input logic [15:0] v, input logic [14:0] o,
                                     input logic [8:0] g);
    int p;
    p = ($signed(v) + $signed(o)) * int'(g);
    return p[23:8];
  endfunction

  // Byte k of the image is the trim register at index 0x22 + k.
  function automatic logic [63:0] pack(input att_trim_t t);
    return {t.z_gain_low_byte[7:0], t.y_gain_low_byte[7:0], t.x_gain_low_byte[7:0], t.z_gain_low_byte[8], t.z_offset_trim[14:8], t.z_offset_trim[7:0],
            t.y_gain_low_byte[8], t.y_offset_trim[14:8], t.y_offset_trim[7:0], t.x_gain_low_byte[8], t.xOffHi};
  endfunction

  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [47:0] e, input logic [47:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    u_host.xfer(1'b1, i, d, rb);
  endtask

  task automatic rdc(input string n, input logic [7:0] i, input logic [7:0] e);
    u_host.xfer(1'b0, i, 8'h00, rb);
    cmp(n, 48'(e), 48'(rb));
    cmp("hresp", 48'h0, 48'(hresp));
  endtask

  task automatic chkTrims();
    for (int k = 0; k < 8; k++) begin
      rdc("trimByte", 8'h22 + 8'(k), img[8*k +: 8]);
    end
  endtask

  // Only the masked bits change, so bits shared with another trim survive.
  task automatic rmw(input int k, input logic [7:0] msk);
    logic [7:0] d;
    seed = lfsr(seed);
    rdc("trimByte", 8'h22 + 8'(k), img[8*k +: 8]);
    d = (img[8*k +: 8] & ~msk) | (seed[7:0] & msk);
    wr(8'h22 + 8'(k), d);
    img[8*k +: 8] = d;
  endtask

  task automatic newOtp();
    logic [79:0] r;
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      r = {r[63:0], seed};
    end
    otpTrim <= r[63:0];
  endtask

  // Inputs stay within 13 bits so that input plus offset never wraps.
  task automatic send();
    att_axis_t s, e;
    seed = lfsr(seed);
    s = {3{{3{seed[12]}}, seed[12:0]}};
    e = {tr(s.x, {img[6:0], 8'h00}, {img[7], img[47:40]}),
         tr(s.y, img[22:8], {img[23], img[55:48]}), tr(s.z, img[38:24], {img[39], img[63:56]})};
    sampleIn <= s;
    sampleValid <= 1'b1;
    @(posedge clk);
    sampleValid <= 1'b0;
    #1;
    cmp("trimValid", 48'h1, 48'(trimValid));
    cmp("trimOut", e, trimOut);
    if (qen && mq.size() < 32 && !(qmode && mq.size() >= lvl)) mq.push_back(e);
  endtask

  task automatic popAll(input int n);
    popReq <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      cmp("popValid", 48'h1, 48'(popValid));
      cmp("popData", mq.pop_front(), popData);
    end
    popReq <= 1'b0;
  endtask

  task automatic pins(input logic [2:0] e);
    #1;
    cmp("irqPins", 48'(e), 48'({irq, irqPinPrimary, irqPinSecondary}));
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    otpReload = 1'b0;
    sampleValid = 1'b0;
    popReq = 1'b0;
    motionIrq = 1'b0;
    sampleIn = '0;
    newOtp();
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    img = pack(otpTrim);
    repeat (2) @(posedge clk);
    chkTrims();
    rdc("queueCtrl", IDX_QCTRL, 8'h00);
    rdc("unmapped", 8'h40, 8'h00);
    for (int k = 0; k < 8; k++) begin
      rmw(k, 8'h7F << (k & 1));
      send();
    end
    // Unity Y and Z gains let the offset checks see a plain sum.
    img[23] = 1'b1;
    img[39] = 1'b1;
    img[63:48] = 16'h0000;
    for (int k = 2; k < 8; k += 2) begin
      wr(8'h22 + 8'(k), img[8*k +: 8]);
    end
    wr(8'h29, 8'h00);
    send();
    newOtp();
    otpReload <= 1'b1;
    @(posedge clk);
    otpReload <= 1'b0;
    img = pack(otpTrim);
    chkTrims();
    send();
    rdc("count", IDX_QCOUNT, 8'h00);
    wr(IDX_QCTRL, 8'h27);
    wr(IDX_QMASK, 8'h07);
    qen = 1'b1;
    repeat (33) send();
    rdc("count", IDX_QCOUNT, 8'h20);
    rdc("status", IDX_QSTAT, 8'h06);
    motionIrq <= 1'b1;
    pins(3'b111);
    motionIrq <= 1'b0;
    popAll(32);
    rdc("status", IDX_QSTAT, 8'h07);
    wr(IDX_QCTRL, 8'h2F);
    pins(3'b110);
    wr(IDX_QMASK, 8'h00);
    pins(3'b000);
    wr(IDX_QSTAT, 8'h07);
    rdc("status", IDX_QSTAT, 8'h00);
    wr(IDX_QLEVEL, 8'h04);
    wr(IDX_QCTRL, 8'h60);
    qmode = 1'b1;
    lvl = 4;
    repeat (6) send();
    rdc("count", IDX_QCOUNT, 8'h04);
    rdc("status", IDX_QSTAT, 8'h00);
    wr(IDX_QCTRL, 8'h70);
    mq.delete();
    rdc("queueCtrl", IDX_QCTRL, 8'h60);
    rdc("count", IDX_QCOUNT, 8'h00);
    final_report();
  end
endmodule
